// *** control_port_io.v ***
// three-pin control port with direction, latch and bus control muxing
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "ctl_port_regs.vh"

module control_port_io (
    // clock and power-on reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // non power-up reset sources
    input wire external_reset_pin_n,
    input wire wdt_reset,
    // system bus controller, same clock
    input wire bus_ale,
    input wire bus_oe_n,
    input wire bus_wr_n,
    // port pins, three signals each
    input wire [2:0] ctl_pin_in,
    output reg [2:0] ctl_pin_out,
    output reg [2:0] ctl_pin_oe
);

// ***************************************
// apb answer states
// ***************************************
localparam ST_IDLE = 1'b0;
localparam ST_ANSWER = 1'b1;

reg state;
reg next_state;

// ***************************************
// registers and internal state
// ***************************************
reg [2:0] ctl_port_direction;
reg [2:0] ctl_port_latch;
reg [1:0] proc_mode;
reg [2:0] pin_snapshot;
reg [2:0] next_direction;
reg [2:0] next_latch;
reg [1:0] next_mode;
reg [2:0] next_pin_out;
reg [2:0] next_pin_oe;
reg [31:0] next_prdata;
reg next_pslverr;
reg soft_reset;

wire [2:0] pin_level;
wire ext_reset_n_sync;
wire setup_phase;
wire commit;
wire write_commit;
wire bus_active;
wire addr_hit;
wire [1:0] rmw_op;
wire [1:0] rmw_bit;
wire [2:0] rmw_mask;
wire lane0;

// ***************************************
// pin and reset pin synchronisers
// ***************************************

// one synchroniser per port pin
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin_sync
        pin_sync3 #(
            .RESET_VAL(1'b0)
        ) u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .async_in(ctl_pin_in[gi]),
            .sync_out(pin_level[gi])
        );
    end
endgenerate

pin_sync3 #(
    .RESET_VAL(1'b1)
) u_ext_reset_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(external_reset_pin_n),
    .sync_out(ext_reset_n_sync)
);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        soft_reset <= 1'b0;
    end else begin
        soft_reset <= ~ext_reset_n_sync | wdt_reset;
    end
end

// ***************************************
// apb decode
// ***************************************

// setup cycle and completing access cycle
assign setup_phase = psel & ~penable;
assign commit = psel & penable & pready & (state == ST_ANSWER);
assign write_commit = commit & pwrite & ~pslverr;
assign lane0 = pstrb[0];

// known word addresses
assign addr_hit = (paddr == `CTL_ADDR_DIRECTION) ||
                  (paddr == `CTL_ADDR_LATCH) ||
                  (paddr == `CTL_ADDR_RMW) ||
                  (paddr == `CTL_ADDR_MODE);

// bit operation fields from write data
assign rmw_op = pwdata[`CTL_RMW_OP_MSB:`CTL_RMW_OP_LSB];
assign rmw_bit = pwdata[`CTL_RMW_BIT_MSB:`CTL_RMW_BIT_LSB];
assign rmw_mask = (rmw_bit == 2'h0) ? 3'h1 :
                  (rmw_bit == 2'h1) ? 3'h2 :
                  (rmw_bit == 2'h2) ? 3'h4 : 3'h0;

// bus mode only in the two external modes
assign bus_active = (proc_mode == `CTL_MODE_EXT_MICRO) ||
                    (proc_mode == `CTL_MODE_MICROPROC);

// ***************************************
// answer state machine
// ***************************************

// next answer state
always @* begin
    next_state = state;
    case (state)
        ST_IDLE: begin
            if (setup_phase) begin
                next_state = ST_ANSWER;
            end
        end
        ST_ANSWER: begin
            if (commit) begin
                next_state = setup_phase ? ST_ANSWER : ST_IDLE;
            end else if (!psel) begin
                next_state = ST_IDLE;
            end
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
end

// state register
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state <= ST_IDLE;
    end else begin
        state <= next_state;
    end
end

// pready high for the access cycle after each setup
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
    end else begin
        pready <= setup_phase;
    end
end

// pins sampled at the start of the access
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_snapshot <= 3'h0;
    end else if (setup_phase) begin
        pin_snapshot <= pin_level;
    end
end

// ***************************************
// read data
// ***************************************

// read mux, unimplemented bits are zero
always @* begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
        `CTL_ADDR_DIRECTION: begin
            next_prdata[2:0] = ctl_port_direction;
        end
        `CTL_ADDR_LATCH: begin
            next_prdata[2:0] = pin_level;
        end
        `CTL_ADDR_RMW: begin
            next_prdata[2:0] = ctl_port_latch;
        end
        `CTL_ADDR_MODE: begin
            next_prdata[`CTL_MODE_MSB:`CTL_MODE_LSB] = proc_mode;
            next_prdata[`CTL_MODE_BUS_BIT] = bus_active;
        end
        default: begin
            next_pslverr = 1'b1;
        end
    endcase
end

// read data and error registered at the setup edge
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end else if (setup_phase) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_pslverr | (pwrite & ~addr_hit);
    end else if (commit) begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
end

// ***************************************
// direction register
// ***************************************

// soft reset wins over a write
always @* begin
    next_direction = ctl_port_direction;
    if (soft_reset) begin
        next_direction = `CTL_DIRECTION_RESET;
    end else if (write_commit && lane0 &&
                 paddr == `CTL_ADDR_DIRECTION) begin
        // plain load of the written value, no read first
        next_direction = pwdata[2:0];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctl_port_direction <= `CTL_DIRECTION_RESET;
    end else begin
        ctl_port_direction <= next_direction;
    end
end

// ***************************************
// output latch
// ***************************************

// writes and bit operations go to the latch
always @* begin
    next_latch = ctl_port_latch;
    if (write_commit && lane0 && paddr == `CTL_ADDR_LATCH) begin
        next_latch = pwdata[2:0];
    end else if (write_commit && lane0 &&
                 paddr == `CTL_ADDR_RMW) begin
        // operand is the pin snapshot, inputs included
        case (rmw_op)
            `CTL_OP_CLEAR: begin
                next_latch = pin_snapshot & ~rmw_mask;
            end
            `CTL_OP_SET: begin
                next_latch = pin_snapshot | rmw_mask;
            end
            `CTL_OP_TOGGLE: begin
                next_latch = pin_snapshot ^ rmw_mask;
            end
            default: begin
                next_latch = ctl_port_latch;
            end
        endcase
    end
end

// latch kept over soft reset, loads at cycle end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctl_port_latch <= `CTL_LATCH_POR;
    end else begin
        ctl_port_latch <= next_latch;
    end
end

// ***************************************
// processor mode
// ***************************************

// mode select, kept over soft reset
always @* begin
    next_mode = proc_mode;
    if (write_commit && lane0 && paddr == `CTL_ADDR_MODE) begin
        next_mode = pwdata[`CTL_MODE_MSB:`CTL_MODE_LSB];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        proc_mode <= `CTL_MODE_RESET;
    end else begin
        proc_mode <= next_mode;
    end
end

// ***************************************
// pin drivers
// ***************************************

// bus controller owns the pins in bus mode
always @* begin
    if (bus_active) begin
        next_pin_oe = 3'h7;
        next_pin_out[`CTL_PIN_ALE] = bus_ale;
        next_pin_out[`CTL_PIN_OE] = bus_oe_n;
        next_pin_out[`CTL_PIN_WR] = bus_wr_n;
    end else begin
        // zero drives the latch, one is input
        next_pin_oe = ~ctl_port_direction;
        next_pin_out = ctl_port_latch;
    end
end

// pins driven from flip-flops
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctl_pin_out <= 3'h0;
        ctl_pin_oe <= 3'h0;
    end else begin
        ctl_pin_out <= next_pin_out;
        ctl_pin_oe <= next_pin_oe;
    end
end

endmodule

`default_nettype wire

// *** ctl_port_regs.vh ***
// register map, field layout, reset values and modes of the control port
// Behaviour
// - pin 0 is general I/O, or address latch enable in bus mode.
// - pin 1 is general I/O, or output enable in bus mode.
// - pin 2 is general I/O, or write strobe in bus mode.
// - data register keeps bits 2..0; bits 7..3 read as zero.
// - direction register resets to all ones on every reset.
// - latch is unknown after power-on, unchanged by other resets; here power-on loads CTL_LATCH_POR, zero.
// - the other resets are the external reset pin and watchdog reset.
// - every port write is done as a read followed by a write; here only bit operations read first, plain writes load directly.
// - data register reads return pins; writes go to the latch only.
// - bit operations use pin levels, result goes to the latch.
// - a port write lands on the latch at the end of the cycle.
// - a read samples pins at the start of the cycle.
// - direction one makes an input, zero drives the latch out.
// - pins carry bus controls only in the two external bus modes.
// - output enable and write strobe are active low on the bus.
`ifndef CTL_PORT_REGS_VH
`define CTL_PORT_REGS_VH

// register indices; byte address is four times the index
`define CTL_IDX_DIRECTION 8'h14
`define CTL_IDX_LATCH 8'h15
`define CTL_IDX_RMW 8'h16
`define CTL_IDX_MODE 8'h17

// byte addresses on the register bus
`define CTL_ADDR_DIRECTION 12'h050
`define CTL_ADDR_LATCH 12'h054
`define CTL_ADDR_RMW 12'h058
`define CTL_ADDR_MODE 12'h05c

// reset values
`define CTL_DIRECTION_RESET 3'h7
`define CTL_LATCH_POR 3'h0
`define CTL_MODE_RESET 2'h0

// processor modes held in the mode register
`define CTL_MODE_MICRO 2'h0
`define CTL_MODE_EXT_MICRO 2'h1
`define CTL_MODE_MICROPROC 2'h2
`define CTL_MODE_PROT_MICRO 2'h3

// mode register fields
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 1
`define CTL_MODE_BUS_BIT 2

// bit operation register fields and operations
`define CTL_RMW_BIT_LSB 0
`define CTL_RMW_BIT_MSB 1
`define CTL_RMW_OP_LSB 4
`define CTL_RMW_OP_MSB 5
`define CTL_OP_NONE 2'h0
`define CTL_OP_CLEAR 2'h1
`define CTL_OP_SET 2'h2
`define CTL_OP_TOGGLE 2'h3

// pin positions of the bus controls
`define CTL_PIN_ALE 0
`define CTL_PIN_OE 1
`define CTL_PIN_WR 2

`endif

// *** pin_sync3.v ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
    parameter [0:0] RESET_VAL = 1'b0
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // pin in and clean level out
    input wire async_in,
    output reg sync_out
);

reg stage1;
reg stage2;
reg stage3;

// ***************************************
// shift chain; stage1 feeds only stage2
// ***************************************
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stage1 <= RESET_VAL;
        stage2 <= RESET_VAL;
        stage3 <= RESET_VAL;
    end else begin
        stage1 <= async_in;
        stage2 <= stage1;
        stage3 <= stage2;
    end
end

// output follows only once stage2 and stage3 agree
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync_out <= RESET_VAL;
    end else if (stage2 == stage3) begin
        sync_out <= stage3;
    end
end

endmodule

`default_nettype wire

// *** control_port_io_assertions.sv ***
// concurrent checks on the control port register bus and pin drive
`timescale 1ns/100ps
`default_nettype none

module control_port_io_assertions (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // soft resets and pin drive
    input wire logic external_reset_pin_n,
    input wire logic wdt_reset,
    input wire logic [2:0] ctl_pin_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ans_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup cycle");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside access");
    upper_bits_zero_a: assert property (pready && !pwrite |-> prdata[31:3] == 29'h0000_0000)
        else $error("unimplemented read bits not zero");
    err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error without ready or with data");
    oe_after_reset_a: assert property ($rose(presetn) |=> ctl_pin_oe == 3'h0)
        else $error("pins driven right after reset");
    wdt_inputs_a: assert property (wdt_reset |-> ##[1:4]
        (ctl_pin_oe == 3'h0 || ctl_pin_oe == 3'h7))
        else $error("watchdog reset left pins driven");
    pin_reset_inputs_a: assert property (!external_reset_pin_n [*8] |->
        (ctl_pin_oe == 3'h0 || ctl_pin_oe == 3'h7))
        else $error("reset pin left pins driven");

    cover property (psel && penable && pready && pwrite);
    cover property (pslverr);
    cover property (wdt_reset ##3 ctl_pin_oe == 3'h0);
endmodule

bind control_port_io control_port_io_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_reset_pin_n(external_reset_pin_n),
    .wdt_reset(wdt_reset), .ctl_pin_oe(ctl_pin_oe));
`default_nettype wire

// *** ctl_pin_partner.sv ***
// pin-side model: outside levels that yield wherever the port drives
`timescale 1ns/100ps
`default_nettype none

module ctl_pin_partner (
    // levels offered by outside circuits
    input wire logic [2:0] ext_level,
    // port drive
    input wire logic [2:0] ctl_pin_out,
    input wire logic [2:0] ctl_pin_oe,
    // resolved pin levels
    output logic [2:0] ctl_pin_in
);
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ctl_pin_in[i] = ctl_pin_oe[i] ? ctl_pin_out[i] : ext_level[i];
        end
    end
endmodule
`default_nettype wire

// *** control_port_io_bench.sv ***
// self-checking bench for the control port
`timescale 1ns/100ps
`default_nettype none
`include "ctl_port_regs.vh"

module control_port_io_bench;
    // clock, bus, resets and pins
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, bus;
    logic ext_n = 1'b1;
    logic wdt = 1'b0;
    logic ale = 1'b0;
    logic oe_n = 1'b1;
    logic wr_n = 1'b1;
    logic [2:0] ext_level = 3'h5;
    logic [2:0] pin_in, pin_out, pin_oe;
    logic [31:0] op_word [4] = '{32'h0000_0010, 32'h0000_0021, 32'h0000_0032, 32'h0000_0003};
    logic [2:0] op_exp [4] = '{3'h4, 3'h7, 3'h1, 3'h1};
    int bad_count = 0;
    int n_compared = 0;

    always #5 pclk = ~pclk;

    control_port_io u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_reset_pin_n(ext_n), .wdt_reset(wdt),
        .bus_ale(ale), .bus_oe_n(oe_n), .bus_wr_n(wr_n), .ctl_pin_in(pin_in),
        .ctl_pin_out(pin_out), .ctl_pin_oe(pin_oe));
    ctl_pin_partner u_pins (.ext_level(ext_level), .ctl_pin_out(pin_out),
        .ctl_pin_oe(pin_oe), .ctl_pin_in(pin_in));

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end

    // test sequence
    initial begin
        idle(16);
        presetn <= 1'b1;
        apb(1'b0, `CTL_ADDR_DIRECTION, 32'h0000_0000);
        chk("direction", 32'h0000_0007, rd);
        chk("oe", 32'h0000_0000, 32'(pin_oe));
        apb(1'b1, `CTL_ADDR_LATCH, 32'h0000_0000);
        apb(1'b1, `CTL_ADDR_DIRECTION, 32'h0000_0000);
        idle(2);
        chk("oe", 32'h0000_0007, 32'(pin_oe));
        apb(1'b1, `CTL_ADDR_LATCH, 32'h0000_00fd);
        idle(2);
        chk("out", 32'h0000_0005, 32'(pin_out));
        idle(6);
        apb(1'b0, `CTL_ADDR_LATCH, 32'h0000_0000);
        chk("pins", 32'h0000_0005, rd);
        apb(1'b1, `CTL_ADDR_LATCH, 32'h0000_0002);
        apb(1'b0, `CTL_ADDR_LATCH, 32'h0000_0000);
        chk("early read", 32'h0000_0005, rd);
        idle(6);
        apb(1'b0, `CTL_ADDR_LATCH, 32'h0000_0000);
        chk("pins", 32'h0000_0002, rd);
        apb(1'b1, `CTL_ADDR_DIRECTION, 32'h0000_0007);
        idle(8);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `CTL_ADDR_RMW, op_word[i]);
            apb(1'b0, `CTL_ADDR_RMW, 32'h0000_0000);
            chk("bit op", 32'(op_exp[i]), rd);
        end
        apb(1'b1, `CTL_ADDR_DIRECTION, 32'h0000_0000);
        idle(2);
        chk("out", 32'h0000_0001, 32'(pin_out));
        // pin 0 driven only, so the soft reset visibly frees it
        apb(1'b1, `CTL_ADDR_DIRECTION, 32'h0000_0006);
        wdt <= 1'b1;
        idle(1);
        wdt <= 1'b0;
        idle(3);
        apb(1'b0, `CTL_ADDR_DIRECTION, 32'h0000_0000);
        chk("direction", 32'h0000_0007, rd);
        apb(1'b0, `CTL_ADDR_RMW, 32'h0000_0000);
        chk("latch", 32'h0000_0001, rd);
        apb(1'b1, `CTL_ADDR_DIRECTION, 32'h0000_0006);
        ext_n <= 1'b0;
        idle(8);
        ext_n <= 1'b1;
        idle(8);
        apb(1'b0, `CTL_ADDR_DIRECTION, 32'h0000_0000);
        chk("direction", 32'h0000_0007, rd);
        apb(1'b0, `CTL_ADDR_RMW, 32'h0000_0000);
        chk("latch", 32'h0000_0001, rd);
        ale <= 1'b1;
        oe_n <= 1'b0;
        apb(1'b1, `CTL_ADDR_DIRECTION, 32'h0000_0002);
        for (int m = 0; m < 4; m++) begin
            bus = (m == 1 || m == 2);
            apb(1'b1, `CTL_ADDR_MODE, 32'(m));
            idle(3);
            chk("oe", bus ? 32'h0000_0007 : 32'h0000_0005, 32'(pin_oe));
            chk("out", bus ? 32'h0000_0005 : 32'h0000_0001, 32'(pin_out));
            apb(1'b0, `CTL_ADDR_MODE, 32'h0000_0000);
            chk("mode", {29'h0000_0000, bus, 2'(m)}, rd);
        end
        // back to bus mode with output enable and write strobe levels swapped
        apb(1'b1, `CTL_ADDR_MODE, 32'h0000_0002);
        oe_n <= 1'b1;
        wr_n <= 1'b0;
        idle(3);
        chk("out", 32'h0000_0003, 32'(pin_out));
        apb(1'b1, `CTL_ADDR_MODE, 32'h0000_0000);
        apb(1'b0, 12'h0fc, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, 32'(err));
        chk("unmapped data", 32'h0000_0000, rd);
        wrap_up();
    end
endmodule
`default_nettype wire
